// ===== rtl/tpio_top.sv
// Pin function select for three timer general registers, with APB registers
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module tpio_top
  import tpio_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk_sys_in,
  input  wire logic         reset_n_in,
  // APB slave
  input  wire logic         psel_in,
  input  wire logic         penable_in,
  input  wire logic         pwrite_in,
  input  wire logic [7:0]   paddr_in,
  input  wire logic [31:0]  pwdata_in,
  output logic [31:0]       prdata_out,
  output logic              pready_out,
  output logic              pslverr_out,
  // Counters and neighbour events from the timer core
  input  wire logic [W-1:0] ch3_counter_in,
  input  wire logic [W-1:0] ch4_counter_in,
  input  wire logic [W-1:0] ch5_counter_in,
  input  wire logic         ch4_count_step_in,
  input  wire logic         ch3_rega_event_in,
  // Timer pins
  input  wire logic         ch3_pin_c_in,
  output logic              ch3_pin_c_out,
  output logic              ch3_pin_c_oe_out,
  input  wire logic         ch4_pin_a_in,
  output logic              ch4_pin_a_out,
  output logic              ch4_pin_a_oe_out,
  input  wire logic         ch5_pin_a_in,
  output logic              ch5_pin_a_out,
  output logic              ch5_pin_a_oe_out,
  // Event outputs and interrupt
  output logic [2:0]        event_out,
  output logic              irq_out
);

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [7:0]   ch3_low_io_control;
  logic [7:0]   ch4_io_control;
  logic [7:0]   ch5_io_control;
  logic [7:0]   ch3_mode_register;
  logic [W-1:0] ch3_general_reg_c;
  logic [W-1:0] ch4_general_reg_a;
  logic [W-1:0] ch5_general_reg_a;
  logic [2:0]   status;
  logic [2:0]   mask;
  logic [2:0]   events;

  logic         setup;
  logic         access;
  logic         wr_acc;
  logic         rd_acc;
  logic         mapped;
  logic [31:0]  next_rdata;
  logic         buffer_mode_a_enable;

  logic         wr_ch3_io;
  logic         wr_ch4_io;
  logic         wr_ch5_io;
  logic         wr_ch3_grc;
  logic         wr_ch4_gra;
  logic         wr_ch5_gra;
  logic         rd_status;

  logic         ch3_rise;
  logic         ch3_fall;
  logic         ch4_rise;
  logic         ch4_fall;
  logic         ch5_rise;
  logic         ch5_fall;

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------
  assign setup  = psel_in & ~penable_in;
  assign access = psel_in & penable_in;
  assign wr_acc = access & pwrite_in;
  assign rd_acc = access & ~pwrite_in;
  assign pready_out = 1'b1;

  assign wr_ch3_io  = wr_acc & (paddr_in == TPIO_OFF_CH3_LOW_IO);
  assign wr_ch4_io  = wr_acc & (paddr_in == TPIO_OFF_CH4_IO);
  assign wr_ch5_io  = wr_acc & (paddr_in == TPIO_OFF_CH5_IO);
  assign wr_ch3_grc = wr_acc & (paddr_in == TPIO_OFF_CH3_GRC);
  assign wr_ch4_gra = wr_acc & (paddr_in == TPIO_OFF_CH4_GRA);
  assign wr_ch5_gra = wr_acc & (paddr_in == TPIO_OFF_CH5_GRA);
  assign rd_status  = rd_acc & (paddr_in == TPIO_OFF_STATUS);
  assign buffer_mode_a_enable = ch3_mode_register[TPIO_BFA_BIT];

  always_comb begin
    next_rdata = 32'h0000_0000;
    mapped     = 1'b1;
    case (paddr_in)
      TPIO_OFF_CH3_LOW_IO: next_rdata[7:0]   = ch3_low_io_control;
      TPIO_OFF_CH4_IO:     next_rdata[7:0]   = ch4_io_control;
      TPIO_OFF_CH5_IO:     next_rdata[7:0]   = ch5_io_control;
      TPIO_OFF_CH3_MODE:   next_rdata[7:0]   = ch3_mode_register;
      TPIO_OFF_CH3_GRC:    next_rdata[W-1:0] = ch3_general_reg_c;
      TPIO_OFF_CH4_GRA:    next_rdata[W-1:0] = ch4_general_reg_a;
      TPIO_OFF_CH5_GRA:    next_rdata[W-1:0] = ch5_general_reg_a;
      TPIO_OFF_STATUS:     next_rdata[2:0]   = status;
      TPIO_OFF_MASK:       next_rdata[2:0]   = mask;
      default:             mapped            = 1'b0;
    endcase
  end

  // Read data and error are sampled in the setup cycle, shown in the access cycle
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else if (setup) begin
      prdata_out  <= pwrite_in ? 32'h0000_0000 : next_rdata;
      pslverr_out <= ~mapped;
    end else if (!psel_in) begin
      pslverr_out <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ch3_low_io_control <= TPIO_CTRL_RST;
      ch4_io_control     <= TPIO_CTRL_RST;
      ch5_io_control     <= TPIO_CTRL_RST;
      ch3_mode_register  <= TPIO_MODE_RST;
      mask               <= TPIO_MASK_RST;
    end else if (wr_acc) begin
      case (paddr_in)
        TPIO_OFF_CH3_LOW_IO: ch3_low_io_control <= pwdata_in[7:0];
        TPIO_OFF_CH4_IO:     ch4_io_control     <= pwdata_in[7:0];
        TPIO_OFF_CH5_IO:     ch5_io_control     <= pwdata_in[7:0];
        TPIO_OFF_CH3_MODE:   ch3_mode_register  <= pwdata_in[7:0];
        TPIO_OFF_MASK:       mask               <= pwdata_in[2:0];
        default:             mask               <= mask;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Status and interrupt
  // ------------------------------------------------------------------
  // Only bits that the read returned are cleared; a new event always wins
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status <= 3'h0;
    end else begin
      status <= (status & ~(rd_status ? prdata_out[2:0] : 3'h0)) | events;
    end
  end

  assign irq_out   = |(status & mask);
  assign event_out = events;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  tpio_sync u_sync_ch3 (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .pin_in     (ch3_pin_c_in),
    .level_out  (),
    .rise_out   (ch3_rise),
    .fall_out   (ch3_fall)
  );

  tpio_sync u_sync_ch4 (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .pin_in     (ch4_pin_a_in),
    .level_out  (),
    .rise_out   (ch4_rise),
    .fall_out   (ch4_fall)
  );

  tpio_sync u_sync_ch5 (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .pin_in     (ch5_pin_a_in),
    .level_out  (),
    .rise_out   (ch5_rise),
    .fall_out   (ch5_fall)
  );

  // ------------------------------------------------------------------
  // Channel units
  // ------------------------------------------------------------------
  // RQ10 RQ11 fourth channel count step
  // RQ14 buffer mode blocks C
  tpio_chan #(.W(W), .ALT_SRC(1'b1)) u_ch3c (
    .clk_sys_in    (clk_sys_in),
    .reset_n_in    (reset_n_in),
    .mode_in       (ch3_low_io_control[3:0]),
    .mode_wr_in    (wr_ch3_io),
    .mode_wdata_in (pwdata_in[3:0]),
    .blocked_in    (buffer_mode_a_enable),
    .count_in      (ch3_counter_in),
    .gr_wr_in      (wr_ch3_grc),
    .gr_wdata_in   (pwdata_in[W-1:0]),
    .pin_rise_in   (ch3_rise),
    .pin_fall_in   (ch3_fall),
    .alt_event_in  (ch4_count_step_in),
    .gr_out        (ch3_general_reg_c),
    .pin_out       (ch3_pin_c_out),
    .pin_oe_out    (ch3_pin_c_oe_out),
    .event_out     (events[TPIO_EVT_CH3C])
  );

  // RQ12 third channel A event
  tpio_chan #(.W(W), .ALT_SRC(1'b1)) u_ch4a (
    .clk_sys_in    (clk_sys_in),
    .reset_n_in    (reset_n_in),
    .mode_in       (ch4_io_control[3:0]),
    .mode_wr_in    (wr_ch4_io),
    .mode_wdata_in (pwdata_in[3:0]),
    .blocked_in    (1'b0),
    .count_in      (ch4_counter_in),
    .gr_wr_in      (wr_ch4_gra),
    .gr_wdata_in   (pwdata_in[W-1:0]),
    .pin_rise_in   (ch4_rise),
    .pin_fall_in   (ch4_fall),
    .alt_event_in  (ch3_rega_event_in),
    .gr_out        (ch4_general_reg_a),
    .pin_out       (ch4_pin_a_out),
    .pin_oe_out    (ch4_pin_a_oe_out),
    .event_out     (events[TPIO_EVT_CH4A])
  );

  // RQ13 no internal source
  tpio_chan #(.W(W), .ALT_SRC(1'b0)) u_ch5a (
    .clk_sys_in    (clk_sys_in),
    .reset_n_in    (reset_n_in),
    .mode_in       (ch5_io_control[3:0]),
    .mode_wr_in    (wr_ch5_io),
    .mode_wdata_in (pwdata_in[3:0]),
    .blocked_in    (1'b0),
    .count_in      (ch5_counter_in),
    .gr_wr_in      (wr_ch5_gra),
    .gr_wdata_in   (pwdata_in[W-1:0]),
    .pin_rise_in   (ch5_rise),
    .pin_fall_in   (ch5_fall),
    .alt_event_in  (1'b0),
    .gr_out        (ch5_general_reg_a),
    .pin_out       (ch5_pin_a_out),
    .pin_oe_out    (ch5_pin_a_oe_out),
    .event_out     (events[TPIO_EVT_CH5A])
  );

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);

  logic [3:0] m5;
  logic       ch5_match;
  assign m5 = ch5_io_control[3:0];
  assign ch5_match = ~m5[3] & (ch5_counter_in == ch5_general_reg_a);

  sequence ch5_quiet_s;
    !wr_ch5_io && !wr_ch5_gra;
  endsequence

  sequence ch5_match_s(logic [1:0] act);
    ch5_quiet_s and (ch5_match && m5[1:0] == act);
  endsequence

  pin_disabled_a: assert property ( // RQ1
    (!m5[3] && m5[1:0] == 2'h0) |-> !ch5_pin_a_oe_out)
    else $error("pin driven in a disabled compare code");

  init_high_a: assert property ( // RQ2
    (wr_ch5_io && pwdata_in[3:2] == 2'h1 && pwdata_in[1:0] != 2'h0)
      |=> (ch5_pin_a_out && ch5_pin_a_oe_out))
    else $error("initial level not high after write");

  match_low_a: assert property ( // RQ3
    ch5_match_s(TPIO_ACT_LOW) |=> !ch5_pin_a_out)
    else $error("pin not low after match");

  match_high_a: assert property ( // RQ4
    ch5_match_s(TPIO_ACT_HIGH) |=> ch5_pin_a_out)
    else $error("pin not high after match");

  match_toggle_a: assert property ( // RQ5
    ch5_match_s(TPIO_ACT_TOGGLE) |=> (ch5_pin_a_out != $past(ch5_pin_a_out)))
    else $error("pin did not toggle after match");

  rise_capture_a: assert property ( // RQ6
    (m5[3] && m5[1:0] == 2'h0 && ch5_rise) |=> (ch5_general_reg_a == $past(ch5_counter_in)))
    else $error("rising edge did not capture");

  fall_ignored_a: assert property ( // RQ6
    (ch5_quiet_s and (m5[3] && m5[1:0] == 2'h0 && ch5_fall)) |=> $stable(ch5_general_reg_a))
    else $error("falling edge captured in rising mode");

  both_edge_a: assert property ( // RQ8
    (m5[3] && m5[1] && (ch5_rise || ch5_fall)) |-> events[TPIO_EVT_CH5A])
    else $error("edge missed in both-edge mode");

  count_step_a: assert property ( // RQ11
    (ch3_low_io_control[3:2] == 2'h3 && !buffer_mode_a_enable && ch4_count_step_in)
      |=> (ch3_general_reg_c == $past(ch3_counter_in)))
    else $error("count step did not capture");

  neighbour_cap_a: assert property ( // RQ12
    (ch4_io_control[3:2] == 2'h3 && ch3_rega_event_in)
      |=> (ch4_general_reg_a == $past(ch4_counter_in)))
    else $error("neighbour event did not capture");

  buffer_block_a: assert property ( // RQ14
    buffer_mode_a_enable |-> (!events[TPIO_EVT_CH3C] && !ch3_pin_c_oe_out))
    else $error("event from C field in buffer mode");

  status_irq_a: assert property (
    (|(events & mask) && !wr_acc) |=> irq_out)
    else $error("interrupt not raised for masked-in event");

  fall_capture_a: assert property ( // RQ7
    (m5[3] && m5[1:0] == 2'h1 && ch5_fall) |=> (ch5_general_reg_a == $past(ch5_counter_in)))
    else $error("falling edge did not capture");

  alt_pin_ignored_a: assert property ( // RQ9
    (ch4_io_control[3:2] == 2'h3 && !ch3_rega_event_in && !wr_ch4_gra && (ch4_rise || ch4_fall))
      |=> $stable(ch4_general_reg_a))
    else $error("pin edge captured with internal source");

endmodule
`default_nettype wire

// ===== rtl/tpio_pkg.sv
// Constants shared by the timer pin function select block
//
// Contract
// RQ1 - Top bit 0 means compare mode; 0000 and 0100 disable pin; 0001-0011 start low.
// RQ2 - Codes 0101, 0110, 0111 keep compare mode and start the pin high.
// RQ3 - Compare mode, low bits 01: pin goes low on each compare match.
// RQ4 - Compare mode, low bits 10: pin goes high on each compare match.
// RQ5 - Compare mode, low bits 11: pin level inverts on each compare match.
// RQ6 - Pin capture, low bits 00: capture on each rising pin edge.
// RQ7 - Pin capture, low bits 01: capture on each falling pin edge.
// RQ8 - Pin capture, bit 1 set: capture on both edges, bit 0 ignored.
// RQ9 - Third channel C and fourth channel A capture from pin only with code 10xx.
// RQ10 - Third channel C, code 11xx: fourth channel count clock is capture source.
// RQ11 - Under 11xx third channel C captures on each fourth channel count step.
// RQ12 - Fourth channel A, code 11xx: capture on third channel A match or capture.
// RQ13 - Fifth channel A ignores bit 2 in capture mode; own pin always source.
// RQ14 - Third channel buffer mode on: C field ignored, no capture or compare events.
// RQ15 - Each capture event copies the channel counter into its general register.
package tpio_pkg;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] TPIO_OFF_CH3_LOW_IO = 8'h00;
  localparam logic [7:0] TPIO_OFF_CH4_IO     = 8'h04;
  localparam logic [7:0] TPIO_OFF_CH5_IO     = 8'h08;
  localparam logic [7:0] TPIO_OFF_CH3_MODE   = 8'h0c;
  localparam logic [7:0] TPIO_OFF_CH3_GRC    = 8'h10;
  localparam logic [7:0] TPIO_OFF_CH4_GRA    = 8'h14;
  localparam logic [7:0] TPIO_OFF_CH5_GRA    = 8'h18;
  localparam logic [7:0] TPIO_OFF_STATUS     = 8'h1c;
  localparam logic [7:0] TPIO_OFF_MASK       = 8'h20;

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int          TPIO_CTRL_W        = 8;
  localparam int          TPIO_FIELD_W       = 4;
  localparam int          TPIO_BFA_BIT       = 4;
  localparam int          TPIO_EVT_W         = 3;
  localparam int          TPIO_EVT_CH3C      = 0;
  localparam int          TPIO_EVT_CH4A      = 1;
  localparam int          TPIO_EVT_CH5A      = 2;
  localparam logic [7:0]  TPIO_CTRL_RST      = 8'h00;
  localparam logic [7:0]  TPIO_MODE_RST      = 8'h00;
  localparam logic [15:0] TPIO_GR_RST        = 16'hffff;
  localparam logic [2:0]  TPIO_MASK_RST      = 3'h0;

  // ------------------------------------------------------------------
  // Compare actions on the two low field bits
  // ------------------------------------------------------------------
  localparam logic [1:0]  TPIO_ACT_NONE      = 2'h0;
  localparam logic [1:0]  TPIO_ACT_LOW       = 2'h1;
  localparam logic [1:0]  TPIO_ACT_HIGH      = 2'h2;
  localparam logic [1:0]  TPIO_ACT_TOGGLE    = 2'h3;

endpackage

// ===== rtl/tpio_sync.sv
// Two-stage pin synchroniser with edge detection
`timescale 1ns/10ps
`default_nettype none
module tpio_sync (
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic reset_n_in,
  // Pin side
  input  wire logic pin_in,
  // Synchronised side
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic meta;
  logic sync;
  logic prev;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin_in;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level_out = sync;
  assign rise_out  = sync & ~prev;
  assign fall_out  = ~sync & prev;
endmodule
`default_nettype wire

// ===== rtl/tpio_chan.sv
// One general register with its compare output and capture input
`timescale 1ns/10ps
`default_nettype none
module tpio_chan
  import tpio_pkg::*;
#(
  parameter int W       = 16,
  parameter bit ALT_SRC = 1'b1
) (
  // Clock and reset
  input  wire logic         clk_sys_in,
  input  wire logic         reset_n_in,
  // Control field and its write strobe
  input  wire logic [3:0]   mode_in,
  input  wire logic         mode_wr_in,
  input  wire logic [3:0]   mode_wdata_in,
  input  wire logic         blocked_in,
  // Counter and software write of the general register
  input  wire logic [W-1:0] count_in,
  input  wire logic         gr_wr_in,
  input  wire logic [W-1:0] gr_wdata_in,
  // Capture sources
  input  wire logic         pin_rise_in,
  input  wire logic         pin_fall_in,
  input  wire logic         alt_event_in,
  // Results
  output logic [W-1:0]      gr_out,
  output logic              pin_out,
  output logic              pin_oe_out,
  output logic              event_out
);
  logic use_alt;
  logic pin_evt;
  logic cap_evt;
  logic match;

  // Internal source only where the channel has one; else bit 2 is don't care
  assign use_alt = ALT_SRC & mode_in[2];
  always_comb begin
    // Edge select on the two low bits
    if (mode_in[1]) begin
      pin_evt = pin_rise_in | pin_fall_in;
    end else if (mode_in[0]) begin
      pin_evt = pin_fall_in;
    end else begin
      pin_evt = pin_rise_in;
    end
  end
  // RQ6 RQ7 RQ8 pin edge capture
  // RQ9 RQ10 RQ13 source select
  assign cap_evt = ~blocked_in & mode_in[3] & (use_alt ? alt_event_in : pin_evt);
  // RQ14 buffer use blocks events
  assign match = ~blocked_in & ~mode_in[3] & (count_in == gr_out);
  assign event_out = cap_evt | match;
  // RQ1 output disabled codes
  assign pin_oe_out = ~blocked_in & ~mode_in[3] & (mode_in[1:0] != TPIO_ACT_NONE);

  // RQ15 capture copies counter
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gr_out <= TPIO_GR_RST;
    end else if (cap_evt) begin
      gr_out <= count_in;
    end else if (gr_wr_in) begin
      gr_out <= gr_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_out <= 1'b0;
    end else if (mode_wr_in) begin
      // RQ1 RQ2 initial level
      pin_out <= mode_wdata_in[2];
    end else if (match) begin
      case (mode_in[1:0])
        // RQ3 low on match
        TPIO_ACT_LOW:    pin_out <= 1'b0;
        // RQ4 high on match
        TPIO_ACT_HIGH:   pin_out <= 1'b1;
        // RQ5 toggle on match
        TPIO_ACT_TOGGLE: pin_out <= ~pin_out;
        default:         pin_out <= pin_out;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== verification/tpio_pin_model.sv
// Model of the outside world at the three timer pins
`timescale 1ns/10ps
`default_nettype none
module tpio_pin_model (
  // Block side of each pin
  input  wire logic [2:0] out_in,
  input  wire logic [2:0] oe_in,
  // Outside driver levels
  input  wire logic [2:0] drive_in,
  // Resolved pin levels
  output logic [2:0]      level_out
);
  // ------------------------------------------------------------------
  // Pin resolution
  // ------------------------------------------------------------------
  // Block wins while it drives, otherwise the outside driver sets the level
  assign level_out = (oe_in & out_in) | (~oe_in & drive_in);
endmodule
`default_nettype wire

// ===== verification/timer_pin_io_mode_select_tb.sv
// Self-checking bench for the timer pin function select block
`timescale 1ns/10ps
`default_nettype none
module timer_pin_io_mode_select_tb;
  import tpio_pkg::*;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic        clk_sys_in;
  logic        reset_n_in;
  logic        psel_in;
  logic        penable_in;
  logic        pwrite_in;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic [15:0] cnt;
  logic        ch4_count_step_in;
  logic        ch3_rega_event_in;
  logic [2:0]  drive;
  logic [2:0]  lvl;
  logic [2:0]  pout;
  logic [2:0]  poe;
  logic [2:0]  event_out;
  logic        irq_out;
  logic [31:0] rd;
  logic        err;
  int          num_errors;
  int          checks;

  tpio_top #(.W(16)) tpio_top_inst (
    .clk_sys_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out,
    .ch3_counter_in(cnt), .ch4_counter_in(cnt), .ch5_counter_in(cnt),
    .ch4_count_step_in, .ch3_rega_event_in,
    .ch3_pin_c_in(lvl[0]), .ch3_pin_c_out(pout[0]), .ch3_pin_c_oe_out(poe[0]),
    .ch4_pin_a_in(lvl[1]), .ch4_pin_a_out(pout[1]), .ch4_pin_a_oe_out(poe[1]),
    .ch5_pin_a_in(lvl[2]), .ch5_pin_a_out(pout[2]), .ch5_pin_a_oe_out(poe[2]),
    .event_out, .irq_out);

  tpio_pin_model tpio_pin_model_inst (.out_in(pout), .oe_in(poe), .drive_in(drive), .level_out(lvl));

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_in);
  endtask

  task automatic tally_and_finish;
    $display("Counts: %0d comparisons, %0d mismatches", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready_out !== 1'b1 && n < 16);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (n >= 16) begin
      num_errors++;
      tally_and_finish();
    end
    @(posedge clk_sys_in);
  endtask

  task automatic pulse_step;
    ch4_count_step_in <= 1'b1;
    cyc(1);
    ch4_count_step_in <= 1'b0;
    cyc(4);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_regs;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rd, (i < 4) ? 32'h0 : {16'h0, TPIO_GR_RST});
    end
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_compare;
    logic [3:0] k;
    logic       e;
    for (int ch = 0; ch < 3; ch++) begin
      apb(1'b1, 8'(16 + ch * 4), 32'h10);
      for (int c = 0; c < 8; c++) begin
        k = 4'(c);
        apb(1'b1, 8'(ch * 4), 32'(c));
        chk({31'h0, poe[ch]}, {31'h0, k[1:0] != 2'h0});
        if (k[1:0] != 2'h0) begin
          chk({31'h0, pout[ch]}, {31'h0, k[2]});
          cnt <= 16'h0010;
          @(negedge clk_sys_in);
          chk({31'h0, event_out[ch]}, 32'h1);
          cyc(1);
          cnt <= 16'h0000;
          cyc(2);
          e = (k[1:0] == 2'h1) ? 1'b0 : (k[1:0] == 2'h2) ? 1'b1 : ~k[2];
          chk({31'h0, pout[ch]}, {31'h0, e});
        end
      end
    end
    $display("test compare done");
  endtask

  task automatic t_capture;
    logic [3:0]  k;
    logic [31:0] x;
    logic        src;
    for (int ch = 0; ch < 3; ch++) begin
      for (int c = 8; c < 15; c++) begin
        k = 4'(c);
        src = (ch == 2) | ~k[2];
        apb(1'b1, 8'(ch * 4), 32'(c));
        apb(1'b1, 8'(16 + ch * 4), 32'h0);
        cnt <= 16'h0a5a;
        drive[ch] <= 1'b1;
        cyc(8);
        apb(1'b0, 8'(16 + ch * 4), 32'h0);
        x = (src & (k[1] | ~k[0])) ? 32'h0a5a : 32'h0;
        chk(rd, x);
        cnt <= 16'h05a5;
        drive[ch] <= 1'b0;
        cyc(8);
        apb(1'b0, 8'(16 + ch * 4), 32'h0);
        chk(rd, (src & (k[1] | k[0])) ? 32'h05a5 : x);
      end
    end
    $display("test capture done");
  endtask

  task automatic t_alt;
    apb(1'b1, TPIO_OFF_CH3_LOW_IO, 32'hc);
    apb(1'b1, TPIO_OFF_CH3_GRC, 32'h0);
    cnt <= 16'h0777;
    pulse_step();
    apb(1'b0, TPIO_OFF_CH3_GRC, 32'h0);
    chk(rd, 32'h0777);
    apb(1'b0, TPIO_OFF_STATUS, 32'h0);
    apb(1'b1, TPIO_OFF_MASK, 32'h2);
    apb(1'b1, TPIO_OFF_CH4_IO, 32'hc);
    cnt <= 16'h0888;
    for (int i = 0; i < 2; i++) begin
      ch3_rega_event_in <= 1'b1;
      cyc(1);
      ch3_rega_event_in <= 1'b0;
      cyc(4);
      chk({31'h0, irq_out}, 32'(1 - i));
      if (i == 0) begin
        apb(1'b0, TPIO_OFF_CH4_GRA, 32'h0);
        chk(rd, 32'h0888);
        apb(1'b0, TPIO_OFF_STATUS, 32'h0);
        chk(rd, 32'h2);
        chk({31'h0, irq_out}, 32'h0);
        apb(1'b1, TPIO_OFF_MASK, 32'h0);
      end
    end
    $display("test neighbour sources done");
  endtask

  task automatic t_buffer;
    apb(1'b1, TPIO_OFF_CH3_MODE, 32'h10);
    apb(1'b1, TPIO_OFF_CH3_GRC, 32'h0123);
    apb(1'b0, TPIO_OFF_STATUS, 32'h0);
    cnt <= 16'h0999;
    pulse_step();
    apb(1'b0, TPIO_OFF_CH3_GRC, 32'h0);
    chk(rd, 32'h0123);
    apb(1'b0, TPIO_OFF_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h0);
    apb(1'b1, TPIO_OFF_CH3_MODE, 32'h0);
    $display("test buffer mode done");
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    reset_n_in = 1'b0;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 8'h00;
    pwdata_in = 32'h0;
    cnt = 16'h0000;
    ch4_count_step_in = 1'b0;
    ch3_rega_event_in = 1'b0;
    drive = 3'h0;
    num_errors = 0;
    checks = 0;
    cyc(2);
    reset_n_in <= 1'b1;
    cyc(1);
    t_regs();
    t_compare();
    t_capture();
    t_alt();
    t_buffer();
    tally_and_finish();
  end
endmodule
`default_nettype wire
